// *** rtl/pwmsfo_pkg.sv ***
package pwmsfo_pkg;

  // Sizes.
  localparam int NGEN = 2;
  localparam int NOUT = 4;
  localparam int AW   = 12;
  localparam int DW   = 32;
  localparam int RW   = 16;
  localparam int NSH  = 8;

  // Module-level register byte offsets.
  localparam logic [AW-1:0] OFS_MCTL   = 12'h000;
  localparam logic [AW-1:0] OFS_SYNC   = 12'h004;
  localparam logic [AW-1:0] OFS_ENABLE = 12'h008;
  localparam logic [AW-1:0] OFS_INVERT = 12'h00C;
  localparam logic [AW-1:0] OFS_FAULT  = 12'h010;
  localparam logic [AW-1:0] OFS_INTEN  = 12'h014;
  localparam logic [AW-1:0] OFS_RIS    = 12'h018;
  localparam logic [AW-1:0] OFS_ISC    = 12'h01C;
  localparam logic [AW-1:0] OFS_STATUS = 12'h020;

  // Generator blocks: base, stride and offsets within a block.
  localparam logic [AW-1:0] GEN_BASE   = 12'h040;
  localparam logic [AW-1:0] GEN_STRIDE = 12'h040;
  localparam logic [AW-1:0] GOFS_CTL   = 12'h000;
  localparam logic [AW-1:0] GOFS_COUNT = 12'h014;
  // Shadowed registers, index 0..7: period, compare A, compare B, action A,
  // action B, dead-band control, rise delay, fall delay.
  localparam logic [NSH-1:0][AW-1:0] GOFS_SH = {
    12'h030, 12'h02C, 12'h028, 12'h024, 12'h020, 12'h01C, 12'h018, 12'h010};
  localparam int SH_PERIOD = 0;
  localparam int SH_CMPA   = 1;
  localparam int SH_CMPB   = 2;
  localparam int SH_AUX    = 3;

  // Field positions.
  localparam int MCTL_ESYNC   = 2;
  localparam int GCTL_RUN     = 0;
  localparam int GCTL_DBGRUN  = 1;
  localparam int GCTL_GLOBAL  = 2;
  localparam int GCTL_AUXSYNC = 3;
  localparam int GCTL_W       = 4;
  localparam int INT_FAULT    = 0;

  // Reset values.
  localparam logic [RW-1:0]   RST_REG  = 16'h0000;
  localparam logic [NOUT-1:0] RST_MASK = 4'h0;
  localparam logic [DW-1:0]   RD_ZERO  = 32'h0000_0000;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } pwmsfo_bus_t;

  typedef struct packed {
    logic [NOUT-1:0] pwm;
    logic            fault_irq;
  } pwmsfo_pins_t;

  // Active action and dead-band settings handed to the generator datapath.
  typedef logic [NGEN-1:0][NSH-1:SH_AUX][RW-1:0] pwmsfo_cfg_t;

  typedef struct packed {
    logic [NGEN-1:0][NSH-1:0][RW-1:0] sh;
    logic [NGEN-1:0][NSH-1:0][RW-1:0] act;
    logic [NGEN-1:0][GCTL_W-1:0]      gctl;
    logic [NGEN-1:0][RW-1:0]          cnt;
    logic [NGEN-1:0]                  gupd;
    logic [NGEN-1:0]                  sync;
    logic                             esync;
    logic [NOUT-1:0]                  en_sh;
    logic [NOUT-1:0]                  en_act;
    logic [NOUT-1:0]                  inv;
    logic [NOUT-1:0]                  flt_en;
    logic [NOUT-1:0]                  raw;
    logic                             inten;
    logic                             ris;
    pwmsfo_pins_t                     pins;
    logic [DW-1:0]                    rdata;
  } pwmsfo_state_t;

endpackage

// *** rtl/pwmsfo_top.sv ***
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// Contract
// - Writing a generator's sync bit forces its counter to zero.
// - Several sync bits in one write reset those counters in the same cycle.
// - Immediate-mode writes reach the hardware at once.
// - Local mode holds the write and applies it at the next counter zero.
// - Global mode applies only after the global update bit, then counter zero.
// - Each generator selects its own update mode.
// - Period and compare registers use local or global update per control bit.
// - Enable mask, action and dead-band registers may sync; default immediate.
// - Per-output fault enable forces that output inactive while fault is asserted.
// - An asserted fault can raise a processor interrupt.
// - Each generator can stop its counter while the processor is debug halted.
// - Stall either runs to zero then halts, or keeps counting normally.
// - A debug stall never raises an interrupt.
// - One enable register gates each raw generator signal to its pin.
// - Per-output inversion makes the output active low; default active high.
// - Two generators, two signals each, four outputs.
// - Global update bit self-clears after its updates apply; software cannot clear it.
// - Sync bits self-clear after the counter reset, reading zero when done.
module pwmsfo_top (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // Register port.
  input  wire pwmsfo_pkg::pwmsfo_bus_t bus,
  output logic [pwmsfo_pkg::DW-1:0]    rdata,
  // Conditions from outside.
  input  wire logic                    fault,
  input  wire logic                    dbg_halt,
  // Pins and active generator settings.
  output pwmsfo_pkg::pwmsfo_pins_t     pins,
  output pwmsfo_pkg::pwmsfo_cfg_t      gen_cfg
);
  import pwmsfo_pkg::*;

  pwmsfo_state_t s;
  pwmsfo_state_t next_s;

  always_comb begin
    logic [AW-1:0] gb;
    logic          zero;
    logic          commit;
    logic          halt;
    logic [RW-1:0] period;
    gb     = '0;
    zero   = 1'b0;
    commit = 1'b0;
    halt   = 1'b0;
    period = '0;
    next_s = s;
    next_s.sync = '0;
    next_s.rdata = RD_ZERO;

    // Hardware events take effect first so that a write in the same cycle wins.
    for (int g = 0; g < NGEN; g++) begin
      zero   = s.gctl[g][GCTL_RUN] && (s.cnt[g] == RST_REG);
      commit = zero && (!s.gctl[g][GCTL_GLOBAL] || s.gupd[g]);
      if (commit) begin
        for (int i = 0; i < SH_AUX; i++) begin
          next_s.act[g][i] = s.sh[g][i];
        end
        if (s.gctl[g][GCTL_AUXSYNC]) begin
          for (int i = SH_AUX; i < NSH; i++) begin
            next_s.act[g][i] = s.sh[g][i];
          end
        end
        next_s.gupd[g] = 1'b0;
      end
      if (g == 0 && zero && s.esync) begin
        next_s.en_act = s.en_sh;
      end
      // Halting at zero keeps the stalled output pattern glitch free.
      halt   = dbg_halt && !s.gctl[g][GCTL_DBGRUN] && (s.cnt[g] == RST_REG);
      period = commit ? s.sh[g][SH_PERIOD] : s.act[g][SH_PERIOD];
      if (s.sync[g]) begin
        next_s.cnt[g] = RST_REG;
      end else if (s.gctl[g][GCTL_RUN] && !halt) begin
        next_s.cnt[g] = zero ? period : s.cnt[g] - RW'(1);
      end
      next_s.raw[2*g]   = s.cnt[g] < s.act[g][SH_CMPA];
      next_s.raw[2*g+1] = s.cnt[g] < s.act[g][SH_CMPB];
    end

    // Fault status is sticky; a new fault wins over a clear in the same cycle.
    if (bus.wr && bus.addr == OFS_ISC && bus.wdata[INT_FAULT]) begin
      next_s.ris = 1'b0;
    end
    if (fault) begin
      next_s.ris = 1'b1;
    end

    // Register writes.
    if (bus.wr) begin
      unique case (bus.addr)
        OFS_MCTL: begin
          // Merging into the committed value keeps a same-cycle commit from being undone.
          next_s.gupd  = next_s.gupd | bus.wdata[NGEN-1:0];
          next_s.esync = bus.wdata[MCTL_ESYNC];
        end
        OFS_SYNC:   next_s.sync   = bus.wdata[NGEN-1:0];
        OFS_ENABLE: next_s.en_sh  = bus.wdata[NOUT-1:0];
        OFS_INVERT: next_s.inv    = bus.wdata[NOUT-1:0];
        OFS_FAULT:  next_s.flt_en = bus.wdata[NOUT-1:0];
        OFS_INTEN:  next_s.inten  = bus.wdata[INT_FAULT];
        default: begin
          for (int g = 0; g < NGEN; g++) begin
            gb = AW'(GEN_BASE + AW'(g) * GEN_STRIDE);
            if (bus.addr == gb + GOFS_CTL) begin
              next_s.gctl[g] = bus.wdata[GCTL_W-1:0];
            end
            for (int i = 0; i < NSH; i++) begin
              if (bus.addr == gb + GOFS_SH[i]) begin
                next_s.sh[g][i] = bus.wdata[RW-1:0];
              end
            end
          end
        end
      endcase
    end

    // Immediate mode copies the freshly written value straight through.
    for (int g = 0; g < NGEN; g++) begin
      if (!next_s.gctl[g][GCTL_AUXSYNC]) begin
        for (int i = SH_AUX; i < NSH; i++) begin
          next_s.act[g][i] = next_s.sh[g][i];
        end
      end
    end
    if (!next_s.esync) begin
      next_s.en_act = next_s.en_sh;
    end

    // Register reads, answered in the next cycle.
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_MCTL:   next_s.rdata = DW'({s.esync, s.gupd});
        OFS_SYNC:   next_s.rdata = DW'(s.sync);
        OFS_ENABLE: next_s.rdata = DW'(s.en_sh);
        OFS_INVERT: next_s.rdata = DW'(s.inv);
        OFS_FAULT:  next_s.rdata = DW'(s.flt_en);
        OFS_INTEN:  next_s.rdata = DW'(s.inten);
        OFS_RIS:    next_s.rdata = DW'(s.ris);
        OFS_ISC:    next_s.rdata = DW'(s.ris & s.inten);
        OFS_STATUS: next_s.rdata = DW'(fault);
        default: begin
          for (int g = 0; g < NGEN; g++) begin
            gb = AW'(GEN_BASE + AW'(g) * GEN_STRIDE);
            if (bus.addr == gb + GOFS_CTL) begin
              next_s.rdata = DW'(s.gctl[g]);
            end
            if (bus.addr == gb + GOFS_COUNT) begin
              next_s.rdata = DW'(s.cnt[g]);
            end
            for (int i = 0; i < NSH; i++) begin
              if (bus.addr == gb + GOFS_SH[i]) begin
                next_s.rdata = DW'(s.sh[g][i]);
              end
            end
          end
        end
      endcase
    end

    // Output conditioning: mask, invert, then force the fault level last.
    for (int o = 0; o < NOUT; o++) begin
      if (s.flt_en[o] && fault) begin
        next_s.pins.pwm[o] = s.inv[o];
      end else begin
        next_s.pins.pwm[o] = (s.raw[o] & s.en_act[o]) ^ s.inv[o];
      end
    end
    // Only the fault feeds the interrupt; the debug halt never does.
    next_s.pins.fault_irq = next_s.ris & next_s.inten;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign pins  = s.pins;

  always_comb begin
    for (int g = 0; g < NGEN; g++) begin
      for (int i = SH_AUX; i < NSH; i++) begin
        gen_cfg[g][i] = s.act[g][i];
      end
    end
  end

endmodule // pwmsfo_top

// *** tb/pwmsfo_stage.sv ***
`timescale 1ns/1ps
module pwmsfo_stage (
  // Clock and commands.
  input  wire logic       clk,
  input  wire logic       trip,
  input  wire logic       clr,
  // Power stage side.
  input  wire logic [3:0] pwm,
  output logic            fault,
  output logic [3:0]      seen_hi
);
  // The fault line lags the trip by one edge, like a real comparator.
  initial {fault, seen_hi} = '0;
  always @(posedge clk) begin
    fault <= trip;
    seen_hi <= clr ? 4'h0 : seen_hi | pwm;
  end
endmodule // pwmsfo_stage

// *** tb/pwmsfo_sva.sv ***
`timescale 1ns/1ps
module pwmsfo_sva (
  // Clock and reset.
  input wire logic                     clk,
  input wire logic                     nrst,
  // Register port.
  input wire pwmsfo_pkg::pwmsfo_bus_t  bus,
  input wire logic [pwmsfo_pkg::DW-1:0] rdata,
  // Conditions and pins.
  input wire logic                     fault,
  input wire logic                     dbg_halt,
  input wire pwmsfo_pkg::pwmsfo_pins_t pins,
  input wire pwmsfo_pkg::pwmsfo_cfg_t  gen_cfg
);
  import pwmsfo_pkg::*;
  // Copies of the written settings, rebuilt from bus traffic alone.
  logic [3:0]  inv, fen, en;
  logic        esync, inten;
  logic [15:0] per1;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {inv, fen, en, esync, inten, per1} <= '0;
    end else if (bus.wr) begin
      if (bus.addr == OFS_INVERT) inv <= bus.wdata[3:0];
      if (bus.addr == OFS_FAULT) fen <= bus.wdata[3:0];
      if (bus.addr == OFS_ENABLE) en <= bus.wdata[3:0];
      if (bus.addr == OFS_MCTL) esync <= bus.wdata[MCTL_ESYNC];
      if (bus.addr == OFS_INTEN) inten <= bus.wdata[INT_FAULT];
      if (bus.addr == GEN_BASE + GEN_STRIDE + GOFS_SH[SH_PERIOD]) per1 <= bus.wdata[15:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_idle: assert property (!$past(bus.rd) |-> rdata == RD_ZERO)
    else $error("read data not zero outside a read");
  a_shadow_read: assert property (bus.rd && bus.addr == GEN_BASE + GEN_STRIDE + GOFS_SH[SH_PERIOD] |=> rdata[15:0] == per1)
    else $error("period read differs from last write");
  a_fault_force: assert property (fault[*2] |=> ((pins.pwm ^ inv) & fen) == 4'h0)
    else $error("faulted output not at inactive level");
  a_idle_pins: assert property ((!fault && en == 4'h0 && !esync && $stable(inv))[*3] |-> pins.pwm == inv)
    else $error("disabled output not at inverted idle level");
  a_irq_off: assert property (!inten && !$past(inten) |-> !pins.fault_irq)
    else $error("interrupt without enable");
  a_irq_raise: assert property (inten && fault |-> ##[1:2] pins.fault_irq)
    else $error("fault did not raise interrupt");
  a_irq_cause: assert property ($rose(pins.fault_irq) |-> $past(fault) || $past(fault, 2) || $past(bus.wr) || $past(bus.wr, 2))
    else $error("interrupt rose without fault");
  a_sync_clear: assert property (bus.rd && bus.addr == OFS_SYNC && !$past(bus.wr) && !$past(bus.wr, 2) |=> rdata[1:0] == 2'b00)
    else $error("sync bits did not clear");
  a_halt_quiet: assert property (dbg_halt && !fault && !bus.wr |=> $stable(pins.fault_irq))
    else $error("interrupt moved during debug stall");
endmodule // pwmsfo_sva
bind pwmsfo_top pwmsfo_sva pwmsfo_sva_i (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .fault(fault),
  .dbg_halt(dbg_halt), .pins(pins), .gen_cfg(gen_cfg));

// *** tb/pwmsfo_top_test.sv ***
`timescale 1ns/1ps
module pwmsfo_top_test;
  import pwmsfo_pkg::*;
  logic          clk, nrst, dbg_halt, trip, clr;
  logic          fault;
  pwmsfo_bus_t   bus;
  logic [DW-1:0] rdata, got;
  pwmsfo_pins_t  pins;
  pwmsfo_cfg_t   cfg;
  logic [3:0]    seen;
  int            mismatches, check_count;
  localparam logic [AW-1:0] PER = GOFS_SH[SH_PERIOD];
  pwmsfo_top pwmsfo_top_i (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .fault(fault),
    .dbg_halt(dbg_halt), .pins(pins), .gen_cfg(cfg));
  pwmsfo_stage pwmsfo_stage_i (.clk(clk), .trip(trip), .clr(clr), .pwm(pins.pwm), .fault(fault), .seen_hi(seen));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [AW-1:0] gr(input int g, input logic [AW-1:0] o);
    return AW'(GEN_BASE + g * GEN_STRIDE + o);
  endfunction
  task automatic chk(input logic [DW-1:0] s, input logic [DW-1:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bw(input logic [AW-1:0] a, input logic [DW-1:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic br(input logic [AW-1:0] a);
    bus <= '{a, RD_ZERO, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 got = rdata;
    @(posedge clk);
  endtask
  task automatic t_sync();
    for (int g = 0; g < NGEN; g++) begin
      bw(gr(g, PER), 32'h40);
      bw(gr(g, GOFS_CTL), 32'h1);
    end
    idle(9);
    bw(gr(0, GOFS_CTL), 32'h0);
    bw(gr(1, GOFS_CTL), 32'h0);
    br(gr(0, GOFS_COUNT));
    chk(32'(got == RD_ZERO), 32'h0);
    bw(OFS_SYNC, 32'h3);
    idle(2);
    br(OFS_SYNC);
    chk(got, RD_ZERO);
    br(gr(0, GOFS_COUNT));
    chk(got, RD_ZERO);
    br(gr(1, GOFS_COUNT));
    chk(got, RD_ZERO);
  endtask
  task automatic t_upd();
    bw(gr(1, GOFS_CTL), 32'h5);
    bw(gr(0, GOFS_CTL), 32'h1);
    bw(gr(0, PER), 32'h20);
    bw(gr(1, PER), 32'h20);
    bw(OFS_MCTL, 32'h2);
    idle(80);
    bw(gr(0, PER), 32'h300);
    bw(gr(1, PER), 32'h300);
    br(gr(1, PER));
    chk(got, 32'h300);
    idle(80);
    br(gr(0, GOFS_COUNT));
    chk(32'(got > 32'h20), 32'h1);
    br(gr(1, GOFS_COUNT));
    chk(32'(got > 32'h20), 32'h0);
    bw(OFS_MCTL, 32'h2);
    idle(80);
    br(gr(1, GOFS_COUNT));
    chk(32'(got > 32'h20), 32'h1);
    br(OFS_MCTL);
    chk(got, RD_ZERO);
    bw(OFS_MCTL, 32'h2);
    bw(OFS_MCTL, 32'h0);
    br(OFS_MCTL);
    chk(got, 32'h2);
  endtask
  task automatic t_out();
    bw(gr(1, GOFS_CTL), 32'h1);
    for (int g = 0; g < NGEN; g++) begin
      bw(gr(g, PER), 32'h1F);
      bw(gr(g, GOFS_SH[SH_CMPA]), 32'h10);
      bw(gr(g, GOFS_SH[SH_CMPB]), 32'h10);
    end
    bw(OFS_SYNC, 32'h3);
    for (int m = 0; m < 2; m++) begin
      bw(OFS_ENABLE, m ? 32'h5 : 32'hF);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      idle(80);
      chk(32'(seen), m ? 32'h5 : 32'hF);
    end
    bw(OFS_INVERT, 32'h2);
    bw(OFS_FAULT, 32'hF);
    bw(OFS_INTEN, 32'h1);
    trip <= 1'b1;
    idle(4);
    chk(32'(pins.pwm), 32'h2);
    chk(32'(pins.fault_irq), 32'h1);
    trip <= 1'b0;
    idle(3);
    bw(OFS_ISC, 32'h1);
    br(OFS_ISC);
    chk(got, RD_ZERO);
  endtask
  task automatic t_halt();
    dbg_halt <= 1'b1;
    idle(40);
    br(gr(0, GOFS_COUNT));
    chk(got, RD_ZERO);
    chk(32'(pins.fault_irq), 32'h0);
    bw(gr(0, GOFS_CTL), 32'h3);
    br(gr(0, GOFS_COUNT));
    chk(32'(got == RD_ZERO), 32'h0);
    dbg_halt <= 1'b0;
  endtask
  task automatic t_mode();
    bw(gr(0, GOFS_SH[SH_AUX]), 32'h1234);
    chk(32'(cfg[0][SH_AUX]), 32'h1234);
    bw(gr(0, GOFS_CTL), 32'h8);
    bw(gr(0, GOFS_SH[SH_AUX]), 32'h5678);
    bw(OFS_SYNC, 32'h1);
    chk(32'(cfg[0][SH_AUX]), 32'h1234);
    br(gr(0, GOFS_SH[SH_AUX]));
    chk(got, 32'h5678);
    bw(gr(0, GOFS_CTL), 32'h9);
    idle(1);
    chk(32'(cfg[0][SH_AUX]), 32'h5678);
    bw(OFS_MCTL, 32'h4);
    bw(gr(0, GOFS_CTL), 32'h0);
    bw(OFS_SYNC, 32'h1);
    bw(OFS_ENABLE, 32'h0);
    idle(2);
    chk(32'(pins.pwm[0]), 32'h1);
    bw(gr(0, GOFS_CTL), 32'h1);
    idle(2);
    chk(32'(pins.pwm[0]), 32'h0);
    bw(OFS_MCTL, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever.
  initial begin
    #40000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    bus = '0;
    nrst = 1'b0;
    dbg_halt = 1'b0;
    trip = 1'b0;
    clr = 1'b0;
    idle(3);
    nrst <= 1'b1;
    @(posedge clk);
    br(OFS_INVERT);
    chk(got, RD_ZERO);
    br(12'h7FC);
    chk(got, RD_ZERO);
    t_sync();
    t_upd();
    t_out();
    t_halt();
    t_mode();
    report_and_stop();
  end
endmodule // pwmsfo_top_test
